// ==== pkg/beeper_defines.svh ====
// Purpose: Constants of the beeper tone sequencer: timing, limits, map and fields
// Assumes: 10 MHz reference clock, AHB-Lite word registers
// Notes:   Byte addresses; every register is one aligned 32-bit word
//
// How it works
// [R1] One-shot tone runs its milliseconds; the bus write completes at once.
// [R2] One-shot overrides the repeating pattern only while it runs; pattern carries on.
// [R3] Wait-tone sets its done flag only after the tone has stopped.
// [R4] Loudness is held, saved to storage on every change, reloaded after reset.
// [R5] Signed loudness request steps up or down from the present level.
// [R6] Pitch settings from 1 to 4000 Hz are accepted.
// [R7] Nominal pitch 2650 Hz, trimmable per unit for peak loudness.
// [R8] A pitch change is saved to storage and restored after every reset.
// [R9] Reading pitch leaves it unchanged and reports the present value.
// [R10] Factory restore leaves the stored pitch untouched.
// [R11] Software should not change pitch casually; it voids loudness calibration.
// [R12] Pattern sounds on-time, stays silent off-time, repeats until replaced.
// [R13] Pattern request with zero on-time and zero off-time ends the pattern.
// [R14] Pattern with alarm selector plays that alarm sound during on-time.
// [R15] Alarm selector: 1 whoop, 2 annoying, 3 two-tone dee-dah.
// [R16] Sounder is a square wave at pitch, gated by timers, duty from loudness.
`ifndef BEEPER_DEFINES_SVH
`define BEEPER_DEFINES_SVH

`define CLK_HZ        10000000
`define MS_PER_S      1000
`define TICK_MS       1

`define PITCH_DEFAULT 16'h0a5a
`define PITCH_MIN     16'h0001
`define PITCH_MAX     16'h0fa0
`define LOUD_DEFAULT  8'h80
`define LOUD_MAX      8'hff

`define A_ONESHOT     8'h00
`define A_LOUD        8'h04
`define A_PITCH       8'h08
`define A_CYC_ON      8'h0c
`define A_CYC_OFF     8'h10
`define A_STATUS      8'h14
`define A_RESTORE     8'h18

`define F_WAIT        16
`define F_REL         8
`define F_DOWN        9
`define F_ALARM_LO    16
`define F_ALARM_HI    17

`define S_TONE        0
`define S_ONESHOT     1
`define S_PATTERN     2
`define S_WAITDONE    3
`define S_WAITBUSY    4

`define ANNOY_MS      16'h0019
`define DEEDAH_MS     16'h00fa
`define WHOOP_SPAN    16'h03ff

`define NV_LOUD       1'b0
`define NV_PITCH      1'b1
`define HSIZE_WORD    3'h2

`endif

// ==== pkg/beeper_pkg.sv ====
// Purpose: Types of the beeper tone sequencer
// Assumes: Constants come from beeper_defines.svh
// Notes:   Alarm codes follow the selector field values 0..3
package beeper_pkg;

  typedef enum logic [1:0] {ALARM_NONE, ALARM_WHOOP, ALARM_ANNOY, ALARM_DEEDAH} alarm_t;

  typedef struct packed {
    logic        loaded;
    logic [15:0] tick_cnt;
    logic [15:0] os_cnt;
    logic        wait_busy;
    logic        wait_done;
    logic [7:0]  loud;
    logic [15:0] pitch;
    logic [15:0] stage_on;
    alarm_t      stage_alarm;
    logic [15:0] on_ms;
    logic [15:0] off_ms;
    alarm_t      alarm;
    logic        pat_run;
    logic        pat_on;
    logic [15:0] pat_cnt;
    logic [15:0] fx_cnt;
    logic        fx_phase;
    logic [23:0] acc;
    logic        sq;
    logic [7:0]  pwm;
    logic        sounder;
    logic        dp_valid;
    logic        dp_write;
    logic        rd_done;
    logic [7:0]  dp_addr;
    logic [31:0] rdata;
    logic        nv_wr;
    logic        nv_sel;
    logic [15:0] nv_data;
  } state_t;

endpackage

// ==== hdl/beeper_tone_sequencer.sv ====
// Purpose: Beeper tone sequencer with AHB-Lite registers and a PWM sounder drive
// Assumes: Storage controller on the same clock presents saved values from reset onward
// Notes:   Reads take one wait state, writes none; response is always OKAY
`include "beeper_defines.svh"

module beeper_tone_sequencer #(
  parameter int CLK_HZ      = `CLK_HZ,
  parameter int TICK_CYCLES = `CLK_HZ / `MS_PER_S * `TICK_MS
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        hsel_i,
  input  wire logic [7:0]  haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic      [31:0] hrdata_o,
  input  wire logic [7:0]  nv_loudness_i,
  input  wire logic [15:0] nv_pitch_i,
  output logic             nv_wr_o,
  output logic             nv_sel_o,
  output logic      [15:0] nv_data_o,
  output logic             sounder_o
);
  import beeper_pkg::*;

  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);
  localparam logic [23:0] ACC_WRAP  = 24'(CLK_HZ);

  state_t      s;
  state_t      next_s;
  logic        tick;
  logic        take;
  logic        wr_en;
  logic        wr_oneshot;
  logic        wr_loud;
  logic        wr_pitch;
  logic        wr_cyc_off;
  logic        wr_restore;
  logic        os_active;
  logic        gate;
  logic [15:0] eff;
  logic [15:0] fx_len;
  logic [15:0] nxt_len;
  logic [24:0] acc_sum;
  logic [8:0]  loud_sum;

  function automatic logic pitch_ok(input logic [15:0] f);
    pitch_ok = (f >= `PITCH_MIN) && (f <= `PITCH_MAX);
  endfunction

  function automatic logic [31:0] read_word(input state_t st, input logic [7:0] a);
    read_word = '0;
    unique case (a)
      `A_ONESHOT: read_word = {16'h0000, st.os_cnt};
      `A_LOUD:    read_word = {24'h000000, st.loud};
      `A_PITCH:   read_word = {16'h0000, st.pitch};
      `A_CYC_ON:  read_word = {14'h0000, st.alarm, st.on_ms};
      `A_CYC_OFF: read_word = {16'h0000, st.off_ms};
      `A_STATUS:  read_word = {27'h0000000, st.wait_busy, st.wait_done, st.pat_run, os_active_of(st), st.sounder};
      default:    read_word = '0;
    endcase
  endfunction

  function automatic logic os_active_of(input state_t st);
    os_active_of = (st.os_cnt != 16'h0000);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  assign take       = hsel_i && htrans_i[1] && hready_i;
  assign wr_en      = s.dp_valid && s.dp_write && hready_i;
  assign wr_oneshot = wr_en && (s.dp_addr == `A_ONESHOT);
  assign wr_loud    = wr_en && (s.dp_addr == `A_LOUD);
  assign wr_pitch   = wr_en && (s.dp_addr == `A_PITCH);
  assign wr_cyc_off = wr_en && (s.dp_addr == `A_CYC_OFF);
  assign wr_restore = wr_en && (s.dp_addr == `A_RESTORE);
  assign tick       = (s.tick_cnt == TICK_LAST);
  assign os_active  = os_active_of(s);

  // Reads stall one cycle so the word reflects any write just completed
  assign hreadyout_o = !(s.dp_valid && !s.dp_write && !s.rd_done);
  assign hresp_o     = 1'b0;
  assign hrdata_o    = s.rdata;
  assign nv_wr_o     = s.nv_wr;
  assign nv_sel_o    = s.nv_sel;
  assign nv_data_o   = s.nv_data;
  assign sounder_o   = s.sounder;

  ////////////////////////////////////////////////////////////////////////////
  // Tone selection
  always_comb
  begin
    unique case (s.alarm)
      ALARM_ANNOY:  fx_len = `ANNOY_MS;
      ALARM_DEEDAH: fx_len = `DEEDAH_MS;
      default:      fx_len = `WHOOP_SPAN;
    endcase
    eff = s.pitch;
    if (!os_active)
    begin
      unique case (s.alarm)                                          // R14 R15
        ALARM_WHOOP:  eff = (s.pitch >> 1) + s.fx_cnt;
        ALARM_DEEDAH: eff = s.fx_phase ? s.pitch - (s.pitch >> 2) : s.pitch;
        default:      eff = s.pitch;
      endcase
    end
    // One-shot wins only while its own count runs
    gate = os_active ||                                              // R2
           (s.pat_run && s.pat_on && (s.on_ms != 16'h0000) &&
            !((s.alarm == ALARM_ANNOY) && s.fx_phase));
    nxt_len  = s.pat_on ? s.off_ms : s.on_ms;
    acc_sum  = {1'b0, s.acc} + {8'h00, eff, 1'b0};
    loud_sum = s.dp_write && hwdata_i[`F_DOWN] ? 9'({1'b0, s.loud} - {1'b0, hwdata_i[7:0]})
                                               : 9'({1'b0, s.loud} + {1'b0, hwdata_i[7:0]});
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    next_s          = s;
    next_s.nv_wr    = 1'b0;
    next_s.tick_cnt = tick ? 16'h0000 : s.tick_cnt + 16'h0001;
    next_s.pwm      = s.pwm + 8'h01;

    if (!s.loaded)
    begin
      next_s.loaded = 1'b1;
      next_s.loud   = nv_loudness_i;                                 // R4
      next_s.pitch  = pitch_ok(nv_pitch_i) ? nv_pitch_i : `PITCH_DEFAULT; // R7 R8
    end

    if (tick && os_active)
      next_s.os_cnt = s.os_cnt - 16'h0001;                           // R1

    if (tick && s.pat_run)
    begin
      if (s.pat_cnt > 16'h0001)
        next_s.pat_cnt = s.pat_cnt - 16'h0001;
      else if (nxt_len != 16'h0000)
      begin
        next_s.pat_on  = !s.pat_on;                                  // R12
        next_s.pat_cnt = nxt_len;
      end
      else
        next_s.pat_cnt = s.pat_on ? s.on_ms : s.off_ms;
    end

    if (tick)
    begin
      if (s.fx_cnt >= fx_len)
      begin
        next_s.fx_cnt   = 16'h0000;
        next_s.fx_phase = !s.fx_phase;
      end
      else
        next_s.fx_cnt = s.fx_cnt + 16'h0001;
    end

    // Square wave by phase accumulation: no divider, toggles at twice the pitch
    if (!gate)
    begin
      next_s.acc = 24'h000000;
      next_s.sq  = 1'b0;
    end
    else if (acc_sum >= {1'b0, ACC_WRAP})
    begin
      next_s.acc = 24'(acc_sum - {1'b0, ACC_WRAP});
      next_s.sq  = !s.sq;
    end
    else
      next_s.acc = acc_sum[23:0];
    next_s.sounder = gate && s.sq && (s.pwm < s.loud);               // R16

    // Bus address and data phases
    if (hready_i)
    begin
      next_s.dp_valid = take && (hsize_i == `HSIZE_WORD);
      next_s.dp_write = hwrite_i;
      next_s.dp_addr  = haddr_i;
      next_s.rd_done  = 1'b0;
    end
    else if (s.dp_valid && !s.dp_write && !s.rd_done)
    begin
      next_s.rdata   = read_word(s, s.dp_addr);                      // R9
      next_s.rd_done = 1'b1;
    end

    if (wr_oneshot)
    begin
      next_s.os_cnt    = hwdata_i[15:0];                             // R1
      next_s.wait_busy = hwdata_i[`F_WAIT];                          // R3
    end
    if (wr_loud)
    begin
      if (hwdata_i[`F_REL])                                          // R5
        next_s.loud = loud_sum[8] ? (hwdata_i[`F_DOWN] ? 8'h00 : `LOUD_MAX) : loud_sum[7:0];
      else
        next_s.loud = hwdata_i[7:0];
    end
    if (wr_restore)
      next_s.loud = `LOUD_DEFAULT;                                   // R10
    if (wr_loud || wr_restore)
    begin
      next_s.nv_wr   = 1'b1;                                         // R4
      next_s.nv_sel  = `NV_LOUD;
      next_s.nv_data = {8'h00, next_s.loud};
    end
    if (wr_pitch && pitch_ok(hwdata_i[15:0]))                        // R6
    begin
      next_s.pitch   = hwdata_i[15:0];
      next_s.nv_wr   = 1'b1;                                         // R8
      next_s.nv_sel  = `NV_PITCH;
      next_s.nv_data = hwdata_i[15:0];
    end
    if (wr_en && (s.dp_addr == `A_CYC_ON))
    begin
      next_s.stage_on    = hwdata_i[15:0];
      next_s.stage_alarm = alarm_t'(hwdata_i[`F_ALARM_HI:`F_ALARM_LO]); // R15
    end
    if (wr_cyc_off)
    begin
      next_s.on_ms    = s.stage_on;
      next_s.off_ms   = hwdata_i[15:0];
      next_s.alarm    = s.stage_alarm;                               // R14
      next_s.pat_run  = (s.stage_on != 16'h0000) || (hwdata_i[15:0] != 16'h0000); // R13
      next_s.pat_on   = 1'b1;
      next_s.pat_cnt  = s.stage_on;
      next_s.fx_cnt   = 16'h0000;
      next_s.fx_phase = 1'b0;
    end
    if (wr_en && (s.dp_addr == `A_STATUS) && hwdata_i[`S_WAITDONE])
      next_s.wait_done = 1'b0;

    // Completion is raised last so it wins over a clear in the same cycle
    if (s.wait_busy && !os_active && !wr_oneshot)
    begin
      next_s.wait_busy = 1'b0;
      next_s.wait_done = 1'b1;                                       // R3
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      s <= '0;
    else
      s <= next_s;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  // Write acknowledge is checked in the data phase itself, the count one cycle later
  oneshot_load_a: assert property (wr_oneshot |-> hreadyout_o ##1 s.os_cnt == $past(hwdata_i[15:0])) // R1
    else $error("one-shot count not taken at once");
  oneshot_prio_a: assert property (os_active |-> gate)               // R2
    else $error("one-shot tone not gating the sounder");
  // Only a new pattern request may stop a running pattern
  pattern_keeps_a: assert property (s.pat_run && !wr_cyc_off |=> s.pat_run) // R2
    else $error("pattern lost without a new pattern request");
  wait_done_a: assert property ($rose(s.wait_done) |-> $past(s.os_cnt) == 16'h0000 && !s.wait_busy) // R3
    else $error("wait completion before tone stopped");
  loud_save_a: assert property (wr_loud |=> s.nv_wr && s.nv_sel == `NV_LOUD && s.nv_data[7:0] == s.loud) // R4
    else $error("loudness change not saved");
  loud_step_a: assert property (wr_loud && hwdata_i[`F_REL] && !hwdata_i[`F_DOWN] |=> s.loud >= $past(s.loud)) // R5
    else $error("relative loudness step went the wrong way");
  pitch_range_a: assert property (s.loaded |-> pitch_ok(s.pitch))    // R6
    else $error("pitch outside accepted range");
  pitch_save_a: assert property (wr_pitch && pitch_ok(hwdata_i[15:0]) |=> s.nv_wr && s.nv_sel == `NV_PITCH && s.nv_data == s.pitch) // R8
    else $error("pitch change not saved");
  restore_keep_a: assert property (wr_restore |=> s.pitch == $past(s.pitch) && s.loud == `LOUD_DEFAULT) // R10
    else $error("factory restore touched pitch");
  pattern_stop_a: assert property (wr_cyc_off && s.stage_on == 16'h0000 && hwdata_i[15:0] == 16'h0000 |=> !s.pat_run) // R13
    else $error("zero pattern did not stop");
  tone_gate_a: assert property (!gate |=> !s.sounder && s.acc == 24'h000000) // R16
    else $error("sounder driven outside a gated interval");
  // Duty compare uses the level of the cycle before, as the sounder flop does
  loud_duty_a: assert property (s.sounder |-> $past(s.pwm) < $past(s.loud)) // R16
    else $error("sounder high outside its loudness duty");
  // A zero-length phase is skipped, so only a nonzero next phase must flip
  logic phase_end;
  assign phase_end = tick && s.pat_run && (s.pat_cnt <= 16'h0001) && (nxt_len != 16'h0000) && !wr_cyc_off;
  pattern_phase_a: assert property (phase_end |=> s.pat_on != $past(s.pat_on)) // R12
    else $error("pattern phase did not change at its end");
  // No completion while the one-shot count still runs
  wait_hold_a: assert property (os_active |=> !$rose(s.wait_done)) // R3
    else $error("wait completion while tone still running");

  // Covers mark the scenarios the bench is meant to reach
  oneshot_end_c: cover property (os_active ##1 !os_active);
  pattern_resume_c: cover property (s.pat_run && os_active ##1 s.pat_run && !os_active);
  pattern_flip_c: cover property (s.pat_run && s.pat_on ##1 !s.pat_on);
  wait_done_c: cover property ($rose(s.wait_done));
  alarm_run_c: cover property (s.pat_run && s.alarm == ALARM_DEEDAH && s.fx_phase);

endmodule

// ==== dv/nv_store_model.sv ====
// Purpose: Storage model on the far side of the save port
// Assumes: Same clock as the sequencer; saved values are visible from time zero
// Notes:   Starts with an out-of-range pitch so the reload fallback is exercised
`include "beeper_defines.svh"

module nv_store_model #(
  parameter logic [7:0]  LOUD_INIT  = 8'h33,
  parameter logic [15:0] PITCH_INIT = 16'h0000
) (
  input  wire logic        ref_clk_i,
  input  wire logic        nv_wr_i,
  input  wire logic        nv_sel_i,
  input  wire logic [15:0] nv_data_i,
  output logic      [7:0]  nv_loudness_o = LOUD_INIT,
  output logic      [15:0] nv_pitch_o = PITCH_INIT
);
  timeunit 1ns;
  timeprecision 1ns;

  // Contents survive the sequencer's reset, as real storage would
  always @(posedge ref_clk_i)
  begin
    if (nv_wr_i === 1'b1 && nv_sel_i === `NV_LOUD)
      nv_loudness_o <= nv_data_i[7:0];
    if (nv_wr_i === 1'b1 && nv_sel_i === `NV_PITCH)
      nv_pitch_o <= nv_data_i;
  end
endmodule

// ==== dv/beeper_tone_sequencer_bench.sv ====
// Purpose: Self-checking bench for the beeper tone sequencer
// Assumes: 1 ms is TICK cycles; a lowered CLK_HZ keeps tone periods short
// Notes:   Bus signals are sampled at the falling edge, where they are settled
`include "beeper_defines.svh"

module beeper_tone_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import beeper_pkg::*;
  localparam int TICK = 10;
  logic        ref_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rv;
  wire logic        hready;
  wire logic        hresp;
  wire logic        nv_wr;
  wire logic        nv_sel;
  wire logic        sounder;
  wire logic [31:0] hrdata;
  wire logic [15:0] nv_data;
  wire logic [15:0] nv_pitch;
  wire logic [7:0]  nv_loud;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  int hi;

  always #50 ref_clk_i = ~ref_clk_i;

  beeper_tone_sequencer #(.CLK_HZ(40000), .TICK_CYCLES(TICK)) dut_u (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata), .nv_loudness_i(nv_loud),
    .nv_pitch_i(nv_pitch), .nv_wr_o(nv_wr), .nv_sel_o(nv_sel), .nv_data_o(nv_data), .sounder_o(sounder));

  nv_store_model store_u (.ref_clk_i(ref_clk_i), .nv_wr_i(nv_wr), .nv_sel_i(nv_sel), .nv_data_i(nv_data),
    .nv_loudness_o(nv_loud), .nv_pitch_o(nv_pitch));

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  always @(posedge ref_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      n_mismatch++;
      summarize();
    end
  end

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Value of hready just before the edge is the value the edge samples
  task automatic wait_rdy(output logic [31:0] d);
    logic ok;
    ok = 1'b0;
    while (!ok)
    begin
      @(negedge ref_clk_i);
      ok = (hready === 1'b1);
      d = hrdata;
      @(posedge ref_clk_i);
    end
  endtask

  task automatic xfer(logic wr, logic [7:0] a, logic [31:0] wd, output logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    wait_rdy(d);
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy(d);
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask

  task automatic rdchk(string what, logic [7:0] a, logic [31:0] m, logic [31:0] exp);
    logic [31:0] d;
    xfer(1'b0, a, 32'h0, d);
    chk(what, exp, d & m);
    chk("hresp okay", 32'h0, {31'h0, hresp});
  endtask

  // Counts sounding cycles over a window
  task automatic sound(int n);
    hi = 0;
    repeat (n)
    begin
      @(negedge ref_clk_i);
      if (sounder === 1'b1)
        hi++;
    end
    @(posedge ref_clk_i);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_settings();
    logic [31:0] pv [5] = '{32'd4000, 32'd4001, 32'd0, 32'd1, 32'd2650};
    logic [31:0] pe [5] = '{32'd4000, 32'd4000, 32'd4000, 32'd1, 32'd2650};
    logic [31:0] lv [6] = '{32'h010, 32'h120, 32'h340, 32'h1ff, 32'h101, 32'h0c0};
    logic [31:0] le [6] = '{32'h10, 32'h30, 32'h00, 32'hff, 32'hff, 32'hc0};
    rdchk("loud reload", `A_LOUD, 32'hff, 32'h33);
    rdchk("pitch nominal", `A_PITCH, 32'hffff, 32'd2650);
    rdchk("unmapped", 8'h1c, 32'hffffffff, 32'h0);
    // Pitch changes kept to this one sweep and the 2500 write before the restore
    for (int i = 0; i < 5; i++)
    begin
      wr(`A_PITCH, pv[i]);
      rdchk("pitch", `A_PITCH, 32'hffff, pe[i]);
      rdchk("pitch again", `A_PITCH, 32'hffff, pe[i]);
    end
    chk("pitch saved", 32'd2650, nv_pitch);
    hsize <= 3'h0;
    wr(`A_LOUD, 32'h55);
    hsize <= `HSIZE_WORD;
    rdchk("loud narrow", `A_LOUD, 32'hff, 32'h33);
    for (int i = 0; i < 6; i++)
    begin
      wr(`A_LOUD, lv[i]);
      rdchk("loud", `A_LOUD, 32'hff, le[i]);
    end
    chk("loud saved", 32'hc0, nv_loud);
    wr(`A_PITCH, 32'd2500);
    wr(`A_RESTORE, 32'h1);
    rdchk("restore loud", `A_LOUD, 32'hff, 32'h80);
    rdchk("restore pitch", `A_PITCH, 32'hffff, 32'd2500);
    chk("restore pitch saved", 32'd2500, nv_pitch);
  endtask

  task automatic t_tones();
    sound(60);
    chk("idle silent", 32'd0, hi);
    wr(`A_LOUD, 32'h0);
    wr(`A_ONESHOT, 32'd20);
    sound(100);
    chk("muted silent", 32'd0, hi);
    wr(`A_LOUD, 32'h80);
    wr(`A_ONESHOT, 32'd30);
    rdchk("oneshot active", `A_STATUS, 32'h2, 32'h2);
    sound(250);
    chk("oneshot sounds", 32'd1, hi > 0);
    repeat (80) @(posedge ref_clk_i);
    rdchk("oneshot over", `A_STATUS, 32'h2, 32'h0);
    wr(`A_ONESHOT, 32'h10005);
    rdchk("wait busy", `A_STATUS, 32'h18, 32'h10);
    repeat (80) @(posedge ref_clk_i);
    rdchk("wait done", `A_STATUS, 32'h18, 32'h08);
    wr(`A_STATUS, 32'h8);
    rdchk("wait cleared", `A_STATUS, 32'h18, 32'h00);
  endtask

  task automatic t_pattern();
    for (int a = 0; a < 4; a++)
    begin
      wr(`A_CYC_ON, (a << 16) | 32'd10);
      wr(`A_CYC_OFF, 32'd10);
      rdchk("pattern on", `A_CYC_ON, 32'h3ffff, (a << 16) | 32'd10);
      rdchk("pattern run", `A_STATUS, 32'h4, 32'h4);
      sound(400);
      chk("pattern sounds", 32'd1, hi > 0);
    end
    wr(`A_ONESHOT, 32'd5);
    repeat (120) @(posedge ref_clk_i);
    rdchk("pattern resumes", `A_STATUS, 32'h6, 32'h4);
    wr(`A_CYC_ON, 32'h0);
    wr(`A_CYC_OFF, 32'h0);
    rdchk("pattern stop", `A_STATUS, 32'h4, 32'h0);
    sound(300);
    chk("stopped silent", 32'd0, hi);
  endtask

  task automatic t_reload();
    rst_n_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    rdchk("loud after reset", `A_LOUD, 32'hff, 32'h80);
    rdchk("pitch after reset", `A_PITCH, 32'hffff, 32'd2500);
  endtask

  initial
  begin
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    t_settings();
    t_tones();
    t_pattern();
    t_reload();
    summarize();
  end
endmodule
